// ===== common/dpts_map.svh
// timing counts and pin layout for the token semaphore port controller
// assumes the including file sits in a 250 MHz clk_sys domain
`ifndef DPTS_MAP_SVH
`define DPTS_MAP_SVH

`define DPTS_CLK_NS      4
`define DPTS_SETUP_NS    8
`define DPTS_STRB_NS     20
`define DPTS_RCV_NS      8
`define DPTS_CYC(ns)     (((ns) + `DPTS_CLK_NS - 1) / `DPTS_CLK_NS)
`define DPTS_SETUP_CYC   `DPTS_CYC(`DPTS_SETUP_NS)
`define DPTS_STRB_CYC    `DPTS_CYC(`DPTS_STRB_NS)
`define DPTS_RCV_CYC     `DPTS_CYC(`DPTS_RCV_NS)
`define DPTS_ADDR_W      13
`define DPTS_DATA_W      9
`define DPTS_IDX_W       3
`define DPTS_TOKENS      8
`define DPTS_MAX_POLLS   4
`define DPTS_FLAG_BIT    0

`endif

// ===== common/dpts_pkg.sv
// types for the token semaphore port controller
// assumes nothing beyond a SystemVerilog compiler
package dpts_pkg;

    typedef enum logic [1:0] {
        DPTS_OP_CLAIM   = 2'b00,
        DPTS_OP_RELEASE = 2'b01,
        DPTS_OP_READ    = 2'b10,
        DPTS_OP_INIT    = 2'b11
    } dpts_op_type;

    typedef enum logic [2:0] {
        DPTS_SQ_IDLE  = 3'b000,
        DPTS_SQ_SETUP = 3'b001,
        DPTS_SQ_STRB  = 3'b010,
        DPTS_SQ_HOLD  = 3'b011,
        DPTS_SQ_RCV   = 3'b100
    } dpts_seq_state_type;

    typedef enum logic [2:0] {
        DPTS_ST_IDLE = 3'b000,
        DPTS_ST_CLW  = 3'b001,
        DPTS_ST_CLR  = 3'b010,
        DPTS_ST_WDR  = 3'b011,
        DPTS_ST_REL  = 3'b100,
        DPTS_ST_RD   = 3'b101,
        DPTS_ST_INI  = 3'b110
    } dpts_state_type;

endpackage : dpts_pkg

// ===== common/dpts_seq_if.sv
// one pin access request from the controller to the pin sequencer
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface dpts_seq_if;
    logic       req;
    logic       wr;
    logic [2:0] idx;
    logic       wbit;
    logic       done;
    logic       rbit;

    modport ctrl (output req, output wr, output idx, output wbit, input done, input rbit);
    modport seq  (input req, input wr, input idx, input wbit, output done, output rbit);
endinterface : dpts_seq_if

// ===== hw/dpts_host.sv
// port-side controller for the eight dual-port token semaphores
// assumes one port of the shared part on these pins; the far port has its own host
// Operation
// - drop select between successive token reads
// - claim by write zero then readback
// - failed claim: keep reading or withdraw
// - start-up writes one to all tokens
// - array select inactive during token access
`timescale 1ns/1ps
`include "dpts_map.svh"
module dpts_host #(
    parameter int MAX_POLLS = `DPTS_MAX_POLLS
) (
    input  logic                      clk_sys,
    input  logic                      resetn,
    input  logic                      cmd_valid,
    output logic                      cmd_ready,
    input  dpts_pkg::dpts_op_type     cmd_op,
    input  logic [`DPTS_IDX_W-1:0]    cmd_index,
    output logic                      rsp_valid,
    output logic                      rsp_granted,
    output logic                      rsp_flag,
    output logic                      array_select_n,
    output logic                      token_space_select_n,
    output logic                      read_enable_n,
    output logic                      write_n,
    output logic [`DPTS_ADDR_W-1:0]   addr,
    input  logic [`DPTS_DATA_W-1:0]   data_in,
    output logic [`DPTS_DATA_W-1:0]   data_out,
    output logic                      data_oe
);
    dpts_seq_if sif ();

    dpts_pkg::dpts_state_type st_r;
    logic [`DPTS_IDX_W-1:0]   idx_r;
    logic [7:0]               polls_r;
    logic                     req_r;
    logic                     wr_r;
    logic                     wbit_r;
    logic                     fail_r;
    logic                     w0_r;

    assign cmd_ready = (st_r == dpts_pkg::DPTS_ST_IDLE);
    assign sif.req   = req_r;
    assign sif.wr    = wr_r;
    assign sif.wbit  = wbit_r;
    assign sif.idx   = idx_r;

    dpts_pin_seq u_seq (
        .clk_sys              (clk_sys),
        .resetn               (resetn),
        .sif                  (sif),
        .array_select_n       (array_select_n),
        .token_space_select_n (token_space_select_n),
        .read_enable_n        (read_enable_n),
        .write_n              (write_n),
        .addr                 (addr),
        .data_in              (data_in),
        .data_out             (data_out),
        .data_oe              (data_oe)
    );

    // operation sequencing; reset starts with the release sweep
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_r        <= dpts_pkg::DPTS_ST_INI;
            idx_r       <= '0;
            polls_r     <= 8'h00;
            req_r       <= 1'b1;
            wr_r        <= 1'b1;
            wbit_r      <= 1'b1;
            rsp_valid   <= 1'b0;
            rsp_granted <= 1'b0;
            rsp_flag    <= 1'b1;
        end else begin
            req_r     <= 1'b0;
            rsp_valid <= 1'b0;
            unique case (st_r)
                dpts_pkg::DPTS_ST_IDLE: if (cmd_valid) begin
                    idx_r   <= cmd_index;
                    polls_r <= 8'h00;
                    req_r   <= 1'b1;
                    wr_r    <= (cmd_op != dpts_pkg::DPTS_OP_READ);
                    wbit_r  <= (cmd_op != dpts_pkg::DPTS_OP_CLAIM);
                    unique case (cmd_op)
                        dpts_pkg::DPTS_OP_CLAIM:   st_r <= dpts_pkg::DPTS_ST_CLW;
                        dpts_pkg::DPTS_OP_RELEASE: st_r <= dpts_pkg::DPTS_ST_REL;
                        dpts_pkg::DPTS_OP_READ:    st_r <= dpts_pkg::DPTS_ST_RD;
                        dpts_pkg::DPTS_OP_INIT: begin
                            st_r  <= dpts_pkg::DPTS_ST_INI;
                            idx_r <= '0;
                        end
                    endcase
                end
                dpts_pkg::DPTS_ST_CLW: if (sif.done) begin
                    st_r  <= dpts_pkg::DPTS_ST_CLR;
                    req_r <= 1'b1;
                    wr_r  <= 1'b0;
                end
                dpts_pkg::DPTS_ST_CLR: if (sif.done) begin
                    if (!sif.rbit) begin
                        st_r        <= dpts_pkg::DPTS_ST_IDLE;
                        rsp_valid   <= 1'b1;
                        rsp_granted <= 1'b1;
                        rsp_flag    <= 1'b0;
                    end else if (polls_r < 8'(MAX_POLLS)) begin
                        polls_r <= polls_r + 8'h01;
                        req_r   <= 1'b1;
                    end else begin
                        st_r   <= dpts_pkg::DPTS_ST_WDR;
                        req_r  <= 1'b1;
                        wr_r   <= 1'b1;
                        wbit_r <= 1'b1;
                    end
                end
                dpts_pkg::DPTS_ST_WDR: if (sif.done) begin
                    st_r        <= dpts_pkg::DPTS_ST_IDLE;
                    rsp_valid   <= 1'b1;
                    rsp_granted <= 1'b0;
                    rsp_flag    <= 1'b1;
                end
                dpts_pkg::DPTS_ST_REL: if (sif.done) begin
                    st_r        <= dpts_pkg::DPTS_ST_IDLE;
                    rsp_valid   <= 1'b1;
                    rsp_granted <= 1'b0;
                    rsp_flag    <= 1'b1;
                end
                dpts_pkg::DPTS_ST_RD: if (sif.done) begin
                    st_r        <= dpts_pkg::DPTS_ST_IDLE;
                    rsp_valid   <= 1'b1;
                    rsp_granted <= !sif.rbit;
                    rsp_flag    <= sif.rbit;
                end
                dpts_pkg::DPTS_ST_INI: if (sif.done) begin
                    if (idx_r == 3'(`DPTS_TOKENS - 1)) begin
                        st_r        <= dpts_pkg::DPTS_ST_IDLE;
                        rsp_valid   <= 1'b1;
                        rsp_granted <= 1'b0;
                        rsp_flag    <= 1'b1;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                        req_r <= 1'b1;
                    end
                end
                default: st_r <= dpts_pkg::DPTS_ST_IDLE;
            endcase
        end
    end

    // helper state for checks: last read of a claim failed, last request was a zero write
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fail_r <= 1'b0;
            w0_r   <= 1'b0;
        end else begin
            if (st_r == dpts_pkg::DPTS_ST_CLR && sif.done) begin
                fail_r <= sif.rbit;
            end else if (st_r == dpts_pkg::DPTS_ST_IDLE) begin
                fail_r <= 1'b0;
            end
            if (sif.req) begin
                w0_r <= sif.wr && !sif.wbit;
            end
        end
    end

    claim_readback_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sif.req && w0_r |-> !sif.wr)
        else $error("zero write not followed by readback");
    grant_src_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && rsp_granted |-> $past(sif.done) && !$past(sif.rbit))
        else $error("grant without zero readback");
    claim_result_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && $past(st_r) == dpts_pkg::DPTS_ST_CLR |-> rsp_granted && !rsp_flag)
        else $error("claim reported without zero readback");
    fail_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sif.req && fail_r |-> !sif.wr || sif.wbit)
        else $error("failed claim followed by zero write");
    poll_bound_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        polls_r <= 8'(MAX_POLLS))
        else $error("reread count past its limit");
    withdraw_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r == dpts_pkg::DPTS_ST_WDR && sif.req |-> sif.wr && sif.wbit)
        else $error("withdrawal did not write one");
    init_ones_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r == dpts_pkg::DPTS_ST_INI && sif.req |-> sif.wr && sif.wbit)
        else $error("start-up sweep wrote zero");
    init_walk_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r == dpts_pkg::DPTS_ST_INI && sif.done && idx_r != 3'h7
        |=> sif.req && idx_r == $past(idx_r) + 3'h1)
        else $error("start-up sweep skipped a token");
    sweep_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_r == dpts_pkg::DPTS_ST_INI && sif.done && idx_r == 3'h7 |=> rsp_valid && cmd_ready)
        else $error("start-up sweep did not finish after last token");

    granted_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && rsp_granted && $past(st_r) == dpts_pkg::DPTS_ST_CLR);
    withdrawn_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && $past(st_r) == dpts_pkg::DPTS_ST_WDR);
    repoll_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        st_r == dpts_pkg::DPTS_ST_CLR && sif.done && sif.rbit ##[1:40] !sif.rbit);
    init_done_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && $past(st_r) == dpts_pkg::DPTS_ST_INI);
    release_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        rsp_valid && $past(st_r) == dpts_pkg::DPTS_ST_REL);
endmodule : dpts_host

// ===== hw/dpts_pin_seq.sv
// pin sequencer: one token read or write cycle on the port pins
// assumes pin inputs synchronous to clk_sys, req only while idle
`timescale 1ns/1ps
`include "dpts_map.svh"
module dpts_pin_seq #(
    parameter int SETUP_CYC = `DPTS_SETUP_CYC,
    parameter int STRB_CYC  = `DPTS_STRB_CYC,
    parameter int RCV_CYC   = `DPTS_RCV_CYC
) (
    input  logic                      clk_sys,
    input  logic                      resetn,
    dpts_seq_if.seq                   sif,
    output logic                      array_select_n,
    output logic                      token_space_select_n,
    output logic                      read_enable_n,
    output logic                      write_n,
    output logic [`DPTS_ADDR_W-1:0]   addr,
    input  logic [`DPTS_DATA_W-1:0]   data_in,
    output logic [`DPTS_DATA_W-1:0]   data_out,
    output logic                      data_oe
);
    dpts_pkg::dpts_seq_state_type st_r;
    dpts_pkg::dpts_seq_state_type st_nxt;
    logic [7:0]                   cnt_r;
    logic [7:0]                   cnt_nxt;
    logic                         wr_r;
    logic                         wr_eff;
    logic                         wbit_r;
    logic                         rbit_r;
    logic                         done_r;

    assign wr_eff   = (st_r == dpts_pkg::DPTS_SQ_IDLE) ? sif.wr : wr_r;
    assign sif.done = done_r;
    assign sif.rbit = rbit_r;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            dpts_pkg::DPTS_SQ_IDLE: if (sif.req) begin
                st_nxt  = dpts_pkg::DPTS_SQ_SETUP;
                cnt_nxt = 8'(SETUP_CYC - 1);
            end
            dpts_pkg::DPTS_SQ_SETUP: if (cnt_r == 8'h00) begin
                st_nxt  = dpts_pkg::DPTS_SQ_STRB;
                cnt_nxt = 8'(STRB_CYC - 1);
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
            dpts_pkg::DPTS_SQ_STRB: if (cnt_r == 8'h00) begin
                st_nxt = dpts_pkg::DPTS_SQ_HOLD;
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
            dpts_pkg::DPTS_SQ_HOLD: begin
                st_nxt  = dpts_pkg::DPTS_SQ_RCV;
                cnt_nxt = 8'(RCV_CYC - 1);
            end
            dpts_pkg::DPTS_SQ_RCV: if (cnt_r == 8'h00) begin
                st_nxt = dpts_pkg::DPTS_SQ_IDLE;
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
            default: st_nxt = dpts_pkg::DPTS_SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_r  <= dpts_pkg::DPTS_SQ_IDLE;
            cnt_r <= 8'h00;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // latch the request
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wr_r   <= 1'b0;
            wbit_r <= 1'b1;
            addr   <= '0;
        end else if (st_r == dpts_pkg::DPTS_SQ_IDLE && sif.req) begin
            wr_r   <= sif.wr;
            wbit_r <= sif.wbit;
            addr   <= {{(`DPTS_ADDR_W-`DPTS_IDX_W){1'b0}}, sif.idx};
        end
    end

    // pins from the next state; array select never driven active
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            array_select_n       <= 1'b1;
            token_space_select_n <= 1'b1;
            read_enable_n        <= 1'b1;
            write_n              <= 1'b1;
            data_oe              <= 1'b0;
            data_out             <= '0;
        end else begin
            array_select_n       <= 1'b1;
            token_space_select_n <= (st_nxt == dpts_pkg::DPTS_SQ_IDLE) ||
                                    (st_nxt == dpts_pkg::DPTS_SQ_RCV);
            read_enable_n        <= !(st_nxt == dpts_pkg::DPTS_SQ_STRB && !wr_eff);
            write_n              <= !(st_nxt == dpts_pkg::DPTS_SQ_STRB && wr_eff);
            data_oe              <= wr_eff && (st_nxt != dpts_pkg::DPTS_SQ_IDLE) &&
                                    (st_nxt != dpts_pkg::DPTS_SQ_RCV);
            data_out             <= {`DPTS_DATA_W{(st_r == dpts_pkg::DPTS_SQ_IDLE) ?
                                    sif.wbit : wbit_r}};
        end
    end

    // sample the held flag at the end of the strobe
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rbit_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            if (st_r == dpts_pkg::DPTS_SQ_STRB && cnt_r == 8'h00 && !wr_r) begin
                rbit_r <= data_in[`DPTS_FLAG_BIT];
            end
            done_r <= (st_r == dpts_pkg::DPTS_SQ_RCV) && (cnt_r == 8'h00);
        end
    end

    array_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        array_select_n) else $error("array select driven active");
    sel_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(read_enable_n) |=> token_space_select_n)
        else $error("select not dropped after read");
    strobe_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!read_enable_n || !write_n) |-> !token_space_select_n && data_oe == !write_n)
        else $error("strobe outside token select");
    read_width_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(read_enable_n) |-> !read_enable_n[*5] ##1 read_enable_n)
        else $error("read strobe width wrong");
endmodule : dpts_pin_seq

// ===== verification/dpts_dev_model.sv
// behavioural model of the shared part's eight token latches, two ports
// assumes port a is the host under test, port b is driven by the bench
`timescale 1ns/1ps
module dpts_dev_model (
    input  logic        a_array_select_n,
    input  logic        a_sel_n,
    input  logic        a_oe_n,
    input  logic        a_we_n,
    input  logic [12:0] a_addr,
    input  logic [8:0]  a_din,
    input  logic        a_din_en,
    output logic [8:0]  a_dout,
    input  logic        b_array_select_n,
    input  logic        b_sel_n,
    input  logic        b_oe_n,
    input  logic        b_we_n,
    input  logic [12:0] b_addr,
    input  logic [8:0]  b_din,
    output logic [8:0]  b_dout
);
    logic [7:0] own_a;
    logic [7:0] own_b;
    logic [7:0] req_a;
    logic [7:0] req_b;
    logic [8:0] q_a;
    logic [8:0] q_b;
    logic       wv_a;
    logic       ok_a;
    logic       wv_b;
    logic       rd_a;
    logic       rd_b;

    // arbitrary power-up contents, requests pending on both sides
    initial begin
        own_a = 8'h0f;
        own_b = 8'hf0;
        req_a = 8'h00;
        req_b = 8'h00;
        q_a = 9'h000;
        q_b = 9'h000;
    end

    task automatic put(input logic side, input logic [2:0] i, input logic v);
        if (side)
            req_b[i] = v;
        else
            req_a[i] = v;
        if (own_a[i] && req_a[i])
            own_a[i] = 1'b0;
        if (own_b[i] && req_b[i])
            own_b[i] = 1'b0;
        if (!own_a[i] && !own_b[i]) begin
            if (!req_a[i])
                own_a[i] = 1'b1;
            else if (!req_b[i])
                own_b[i] = 1'b1;
        end
    endtask : put

    assign rd_a = !a_sel_n && !a_oe_n && a_array_select_n;
    assign rd_b = !b_sel_n && !b_oe_n && b_array_select_n;

    always @(negedge a_we_n) begin
        wv_a = a_din[0];
        ok_a = a_din_en;
    end
    always @(negedge b_we_n) wv_b = b_din[0];
    always @(posedge a_we_n) begin
        if (!a_sel_n && a_array_select_n && ok_a)
            put(1'b0, a_addr[2:0], wv_a);
    end
    always @(posedge b_we_n) begin
        if (!b_sel_n && b_array_select_n)
            put(1'b1, b_addr[2:0], wv_b);
    end
    always @(posedge rd_a) q_a = {9{~own_a[a_addr[2:0]]}};
    always @(posedge rd_b) q_b = {9{~own_b[b_addr[2:0]]}};
    // idle or standby: bus shows the inverse of the last read
    assign a_dout = rd_a ? q_a : ~q_a;
    assign b_dout = rd_b ? q_b : ~q_b;
endmodule : dpts_dev_model

// ===== verification/testbench.sv
// self-checking bench: host on port a, bench acts as far processor on port b
// assumes the device model and the design files are compiled first
`timescale 1ns/1ps
module testbench;
    logic                  clk_sys;
    logic                  resetn;
    logic                  cmd_valid;
    logic                  cmd_ready;
    dpts_pkg::dpts_op_type cmd_op;
    logic [2:0]            cmd_index;
    logic                  rsp_valid;
    logic                  rsp_granted;
    logic                  rsp_flag;
    logic                  a_arr_n;
    logic                  a_sel_n;
    logic                  a_oe_n;
    logic                  a_we_n;
    logic [12:0]           a_addr;
    logic [8:0]            a_rd;
    logic [8:0]            a_wd;
    logic                  a_en;
    logic                  b_sel_n;
    logic                  b_oe_n;
    logic                  b_we_n;
    logic [12:0]           b_addr;
    logic [8:0]            b_din;
    logic [8:0]            b_dout;
    logic [1:0]            exp_q[$];
    logic [31:0]           rnd;
    int                    n_errors;
    int                    num_checks;
    int                    cyc;

    dpts_host #(.MAX_POLLS(4)) dut (.clk_sys(clk_sys), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_index(cmd_index), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted),
        .rsp_flag(rsp_flag), .array_select_n(a_arr_n), .token_space_select_n(a_sel_n),
        .read_enable_n(a_oe_n), .write_n(a_we_n), .addr(a_addr), .data_in(a_rd),
        .data_out(a_wd), .data_oe(a_en));

    dpts_dev_model dev (.a_array_select_n(a_arr_n), .a_sel_n(a_sel_n), .a_oe_n(a_oe_n),
        .a_we_n(a_we_n), .a_addr(a_addr), .a_din(a_wd), .a_din_en(a_en), .a_dout(a_rd),
        .b_array_select_n(1'b1), .b_sel_n(b_sel_n), .b_oe_n(b_oe_n), .b_we_n(b_we_n),
        .b_addr(b_addr), .b_din(b_din), .b_dout(b_dout));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_rsp

    task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // expectation is {granted, flag}; returns once the command is taken
    task automatic host_cmd(input dpts_pkg::dpts_op_type op, input logic [2:0] i,
                            input logic [1:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_index <= i;
        do @(negedge clk_sys); while (cmd_ready !== 1'b1);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask : host_cmd

    task automatic wait_rsp;
        for (int k = 0; k < 300 && exp_q.size() != 0; k++)
            @(posedge clk_sys);
    endtask : wait_rsp

    // upper address and data bits random: the part must ignore them
    task automatic b_write(input logic [2:0] i, input logic v);
        @(posedge clk_sys);
        b_addr <= {rnd[9:0], i};
        b_din <= {rnd[17:10], v};
        b_sel_n <= 1'b0;
        rnd = lfsr(rnd);
        @(posedge clk_sys);
        b_we_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        b_we_n <= 1'b1;
        @(posedge clk_sys);
        b_sel_n <= 1'b1;
        @(posedge clk_sys);
    endtask : b_write

    task automatic b_read(input logic [2:0] i, input logic [8:0] exp, input logic hold);
        @(posedge clk_sys);
        b_addr <= {rnd[12:3], i};
        b_sel_n <= 1'b0;
        b_oe_n <= 1'b0;
        rnd = lfsr(rnd);
        repeat (2) @(posedge clk_sys);
        chk_pin(b_dout, exp);
        if (!hold) begin
            @(posedge clk_sys);
            b_sel_n <= 1'b1;
            b_oe_n <= 1'b1;
        end
    endtask : b_read

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_errors++;
            report_and_stop;
        end
        if (resetn === 1'b1 && a_sel_n === 1'b0)
            chk_pin({a_arr_n, a_addr[12:5]}, 9'h100);
        if (resetn === 1'b1 && a_we_n === 1'b0)
            chk_pin({6'h00, a_addr[4:3], a_en}, 9'h001);
        if (resetn === 1'b1 && rsp_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk_rsp({rsp_granted, rsp_flag}, 2'h3);
            else
                chk_rsp({rsp_granted, rsp_flag}, exp_q.pop_front());
        end
    end

    initial begin
        logic [2:0] i;
        logic [2:0] perm;
        n_errors = 0;
        num_checks = 0;
        cyc = 0;
        rnd = 32'h7d0f;
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = dpts_pkg::DPTS_OP_READ;
        cmd_index = 3'h0;
        b_sel_n = 1'b1;
        b_oe_n = 1'b1;
        b_we_n = 1'b1;
        b_addr = 13'h0000;
        b_din = 9'h000;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        exp_q.push_back(2'h1);
        for (int k = 0; k < 8; k++)
            b_write(k[2:0], 1'b1);
        wait_rsp;
        rnd = lfsr(rnd);
        perm = rnd[2:0];
        for (int k = 0; k < 8; k++) begin
            i = k[2:0] ^ perm;
            host_cmd(dpts_pkg::DPTS_OP_CLAIM, i, 2'h2);
            wait_rsp;
            b_read(i, 9'h1ff, 1'b0);
            b_read(i + 3'h1, 9'h1ff, 1'b0);
            b_write(i, 1'b0);
            b_read(i, 9'h1ff, 1'b0);
            host_cmd(dpts_pkg::DPTS_OP_READ, i, 2'h2);
            wait_rsp;
            host_cmd(dpts_pkg::DPTS_OP_RELEASE, i, 2'h1);
            wait_rsp;
            b_read(i, 9'h000, 1'b0);
            host_cmd(dpts_pkg::DPTS_OP_CLAIM, i, 2'h1);
            wait_rsp;
            host_cmd(dpts_pkg::DPTS_OP_CLAIM, i, 2'h2);
            repeat (30) @(posedge clk_sys);
            b_write(i, 1'b1);
            wait_rsp;
            b_write(i, 1'b0);
            b_read(i, 9'h1ff, 1'b1);
            host_cmd(dpts_pkg::DPTS_OP_RELEASE, i, 2'h1);
            wait_rsp;
            chk_pin(b_dout, 9'h1ff);
            @(posedge clk_sys);
            b_sel_n <= 1'b1;
            b_oe_n <= 1'b1;
            b_read(i, 9'h000, 1'b0);
            b_write(i, 1'b1);
            host_cmd(dpts_pkg::DPTS_OP_READ, i, 2'h1);
            wait_rsp;
            host_cmd(dpts_pkg::DPTS_OP_CLAIM, i, 2'h1);
            b_write(i, 1'b0);
            wait_rsp;
            b_read(i, 9'h000, 1'b0);
            b_write(i, 1'b1);
        end
        host_cmd(dpts_pkg::DPTS_OP_INIT, 3'h0, 2'h1);
        wait_rsp;
        report_and_stop;
    end
endmodule : testbench
